// File: hdl/nonlinearity_coeff_regs.v
// nonlinearity correction coefficient register bank, words 0xAC..0xB1
`timescale 1ns/1ps
`default_nettype none
`include "coeff_bank_defines.vh"

module nonlinearity_coeff_regs (
	input  wire                       mclk_in,
	input  wire                       rst_n_in,
	// register port of the control interface, same clock domain
	input  wire                       reg_wr_in,
	input  wire [`COEFF_ADDR_W-1:0]   reg_addr_in,
	input  wire [`COEFF_DATA_W-1:0]   reg_wdata_in,
	output wire                       reg_hit_out,
	output wire [`COEFF_DATA_W-1:0]   reg_rdata_out,
	// measurement selection from the sequencer
	input  wire                       meas_start_in,
	input  wire [`COEFF_CH_W-1:0]     meas_ch_in,
	input  wire                       meas_high_in,
	// coefficient set for the correction datapath
	output reg  [15:0]                quadratic_out,
	output reg  [15:0]                quartic_out,
	output reg                        quartic_valid_out,
	// flat views of the stored coefficients
	output reg  [15:0]                quadratic_high_ch0_out,
	output reg  [15:0]                quadratic_low_ch1_out,
	output reg  [15:0]                quadratic_high_ch1_out,
	output reg  [15:0]                quadratic_low_ch2_out,
	output reg  [15:0]                quadratic_high_ch2_out,
	output reg  [15:0]                quartic_low_ch1_out,
	output reg  [15:0]                quartic_high_ch1_out,
	output reg  [15:0]                quartic_low_ch2_out
);

	// ***********************************************************************
	// address decode
	// ***********************************************************************
	wire [`COEFF_ADDR_W-1:0] offset;
	wire                     in_range;
	wire [`COEFF_IDX_W-1:0]  word_idx;
	wire [`COEFF_DATA_W*`COEFF_NUM_WORDS-1:0] words;
	wire                     store_wr;
	wire [`COEFF_IDX_W-1:0]  store_rd_idx;

	// six words from offset 0xAC upward; other addresses live elsewhere
	assign offset   = reg_addr_in - `COEFF_BASE;
	assign in_range = (reg_addr_in >= `COEFF_WORD_AC) &&
	                  (reg_addr_in <= `COEFF_WORD_B1);
	assign word_idx = offset[`COEFF_IDX_W-1:0];
	assign reg_hit_out = in_range;

	// offsets past the bank alias onto low indices through the cut, so
	// both strobe and read index are gated by the range check
	assign store_wr     = reg_wr_in & in_range;
	assign store_rd_idx = in_range ? word_idx : `COEFF_IDX_NONE;

	// ***********************************************************************
	// storage
	// ***********************************************************************
	// all fields read/write, zero on reset
	coeff_word_store i_coeff_word_store (
		.mclk_in       (mclk_in),
		.rst_n_in      (rst_n_in),
		.wr_en_in      (store_wr),
		.wr_idx_in     (word_idx),
		.wr_data_in    (reg_wdata_in),
		.rd_idx_in     (store_rd_idx),
		.rd_data_out   (reg_rdata_out),
		.all_words_out (words)
	);

	// ***********************************************************************
	// word views, one per register of the map
	// ***********************************************************************
	wire [`COEFF_DATA_W-1:0] coeff_word_ac;
	wire [`COEFF_DATA_W-1:0] coeff_word_ad;
	wire [`COEFF_DATA_W-1:0] coeff_word_ae;
	wire [`COEFF_DATA_W-1:0] coeff_word_af;
	wire [`COEFF_DATA_W-1:0] coeff_word_b0;
	wire [`COEFF_DATA_W-1:0] coeff_word_b1;

	// each word sits in its own slot of the flat store bus
	assign coeff_word_ac = words[0*`COEFF_DATA_W +: `COEFF_DATA_W];
	assign coeff_word_ad = words[1*`COEFF_DATA_W +: `COEFF_DATA_W];
	assign coeff_word_ae = words[2*`COEFF_DATA_W +: `COEFF_DATA_W];
	assign coeff_word_af = words[3*`COEFF_DATA_W +: `COEFF_DATA_W];
	assign coeff_word_b0 = words[4*`COEFF_DATA_W +: `COEFF_DATA_W];
	assign coeff_word_b1 = words[5*`COEFF_DATA_W +: `COEFF_DATA_W];

	// ***********************************************************************
	// field split: quartic bytes in 23:16, quadratic terms in 15:0
	// ***********************************************************************
	wire [7:0]  quartic_low_ch1_upper;
	wire [7:0]  quartic_low_ch1_lower;
	wire [7:0]  quartic_high_ch1_upper;
	wire [7:0]  quartic_high_ch1_lower;
	wire [7:0]  quartic_low_ch2_upper;
	wire [7:0]  quartic_low_ch2_lower;
	wire [15:0] quadratic_high_ch0;
	wire [15:0] quadratic_low_ch1;
	wire [15:0] quadratic_high_ch1;
	wire [15:0] quadratic_low_ch2;
	wire [15:0] quadratic_high_ch2;

	// coeff_word_ac: upper quartic byte of ch1 low, quadratic of ch0 high
	assign quartic_low_ch1_upper =
		coeff_word_ac[`COEFF_BYTE_HI:`COEFF_BYTE_LO];
	assign quadratic_high_ch0 =
		coeff_word_ac[`COEFF_QUAD_HI:`COEFF_QUAD_LO];

	// coeff_word_ad: lower quartic byte of ch1 low, quadratic of ch1 low
	assign quartic_low_ch1_lower =
		coeff_word_ad[`COEFF_BYTE_HI:`COEFF_BYTE_LO];
	assign quadratic_low_ch1 =
		coeff_word_ad[`COEFF_QUAD_HI:`COEFF_QUAD_LO];

	// coeff_word_ae: upper quartic byte of ch1 high, quadratic of ch1 high
	assign quartic_high_ch1_upper =
		coeff_word_ae[`COEFF_BYTE_HI:`COEFF_BYTE_LO];
	assign quadratic_high_ch1 =
		coeff_word_ae[`COEFF_QUAD_HI:`COEFF_QUAD_LO];

	// coeff_word_af: lower quartic byte of ch1 high, quadratic of ch2 low
	assign quartic_high_ch1_lower =
		coeff_word_af[`COEFF_BYTE_HI:`COEFF_BYTE_LO];
	assign quadratic_low_ch2 =
		coeff_word_af[`COEFF_QUAD_HI:`COEFF_QUAD_LO];

	// coeff_word_b0: upper quartic byte of ch2 low, quadratic of ch2 high
	assign quartic_low_ch2_upper =
		coeff_word_b0[`COEFF_BYTE_HI:`COEFF_BYTE_LO];
	assign quadratic_high_ch2 =
		coeff_word_b0[`COEFF_QUAD_HI:`COEFF_QUAD_LO];

	// word b1: lower quartic byte of ch2 low; its low half is only
	// stored and read back, nothing in this bank consumes it
	assign quartic_low_ch2_lower =
		coeff_word_b1[`COEFF_BYTE_HI:`COEFF_BYTE_LO];

	// ***********************************************************************
	// registered coefficient views
	// ***********************************************************************
	// quadratic views, one cycle behind the word store
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			quadratic_high_ch0_out <= `COEFF_HALF_RESET;
			quadratic_low_ch1_out  <= `COEFF_HALF_RESET;
			quadratic_high_ch1_out <= `COEFF_HALF_RESET;
			quadratic_low_ch2_out  <= `COEFF_HALF_RESET;
			quadratic_high_ch2_out <= `COEFF_HALF_RESET;
		end else begin
			quadratic_high_ch0_out <= quadratic_high_ch0;
			quadratic_low_ch1_out  <= quadratic_low_ch1;
			quadratic_high_ch1_out <= quadratic_high_ch1;
			quadratic_low_ch2_out  <= quadratic_low_ch2;
			quadratic_high_ch2_out <= quadratic_high_ch2;
		end
	end

	// quartic views: upper byte from the lower address, lower byte from
	// the next; the halves are two host writes, so update both early
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			quartic_low_ch1_out  <= `COEFF_HALF_RESET;
			quartic_high_ch1_out <= `COEFF_HALF_RESET;
			quartic_low_ch2_out  <= `COEFF_HALF_RESET;
		end else begin
			quartic_low_ch1_out  <= {quartic_low_ch1_upper,
			                         quartic_low_ch1_lower};
			quartic_high_ch1_out <= {quartic_high_ch1_upper,
			                         quartic_high_ch1_lower};
			quartic_low_ch2_out  <= {quartic_low_ch2_upper,
			                         quartic_low_ch2_lower};
		end
	end

	// ***********************************************************************
	// coefficient selection for the datapath
	// ***********************************************************************
	reg [15:0] quad_d;
	reg [15:0] quart_d;
	reg        quart_ok_d;

	// pick the set of the active channel and current; quartic terms of
	// this bank exist only for ch1 both settings and ch2 low
	always @* begin
		quad_d     = 16'h0000;
		quart_d    = 16'h0000;
		quart_ok_d = 1'b0;
		case ({meas_ch_in, meas_high_in})
			{`COEFF_CH0, 1'b1}: begin
				quad_d = quadratic_high_ch0_out;
			end
			{`COEFF_CH1, 1'b0}: begin
				quad_d     = quadratic_low_ch1_out;
				quart_d    = quartic_low_ch1_out;
				quart_ok_d = 1'b1;
			end
			{`COEFF_CH1, 1'b1}: begin
				quad_d     = quadratic_high_ch1_out;
				quart_d    = quartic_high_ch1_out;
				quart_ok_d = 1'b1;
			end
			{`COEFF_CH2, 1'b0}: begin
				quad_d     = quadratic_low_ch2_out;
				quart_d    = quartic_low_ch2_out;
				quart_ok_d = 1'b1;
			end
			{`COEFF_CH2, 1'b1}: begin
				quad_d = quadratic_high_ch2_out;
			end
			default: begin
				quad_d = 16'h0000;
			end
		endcase
	end

	// latched only at measurement start, so a host write mid-measurement
	// cannot tear the set in use
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			quadratic_out     <= `COEFF_HALF_RESET;
			quartic_out       <= `COEFF_HALF_RESET;
			quartic_valid_out <= 1'b0;
		end else if (meas_start_in) begin
			quadratic_out     <= quad_d;
			quartic_out       <= quart_d;
			quartic_valid_out <= quart_ok_d;
		end
	end

endmodule // nonlinearity_coeff_regs

`default_nettype wire

// File: hdl/coeff_bank_defines.vh
// register offsets, field positions and reset values of the coefficient bank
`ifndef COEFF_BANK_DEFINES_VH
`define COEFF_BANK_DEFINES_VH

// ***********************************************************************
// register map (printed offsets, 8-bit register address space)
// ***********************************************************************
`define COEFF_ADDR_W       8
`define COEFF_DATA_W       24
`define COEFF_WORD_AC      8'hAC
`define COEFF_WORD_AD      8'hAD
`define COEFF_WORD_AE      8'hAE
`define COEFF_WORD_AF      8'hAF
`define COEFF_WORD_B0      8'hB0
`define COEFF_WORD_B1      8'hB1
`define COEFF_BASE         8'hAC
`define COEFF_NUM_WORDS    6
`define COEFF_IDX_W        3
`define COEFF_IDX_NONE     3'h7
`define COEFF_HALF_RESET   16'h0000

// ***********************************************************************
// field layout
// ***********************************************************************
`define COEFF_BYTE_HI      23
`define COEFF_BYTE_LO      16
`define COEFF_QUAD_HI      15
`define COEFF_QUAD_LO      0
`define COEFF_RESET_VAL    24'h000000

// ***********************************************************************
// correction selection: channel and current setting
// ***********************************************************************
`define COEFF_CH_W         2
`define COEFF_CH0          2'h0
`define COEFF_CH1          2'h1
`define COEFF_CH2          2'h2

`endif

// File: hdl/coeff_word_store.v
// six-entry register store with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "coeff_bank_defines.vh"

module coeff_word_store (
	input  wire                       mclk_in,
	input  wire                       rst_n_in,
	input  wire                       wr_en_in,
	input  wire [`COEFF_IDX_W-1:0]    wr_idx_in,
	input  wire [`COEFF_DATA_W-1:0]   wr_data_in,
	input  wire [`COEFF_IDX_W-1:0]    rd_idx_in,
	output reg  [`COEFF_DATA_W-1:0]   rd_data_out,
	output wire [`COEFF_DATA_W*`COEFF_NUM_WORDS-1:0] all_words_out
);

	// ***********************************************************************
	// storage
	// ***********************************************************************
	genvar i;
	generate
		for (i = 0; i < `COEFF_NUM_WORDS; i = i + 1) begin : g_word
			reg [`COEFF_DATA_W-1:0] word_q;
			// every word clears to zero, host writes replace whole word
			always @(posedge mclk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					word_q <= `COEFF_RESET_VAL;
				end else if (wr_en_in && wr_idx_in == i) begin
					word_q <= wr_data_in;
				end
			end
			assign all_words_out[i*`COEFF_DATA_W +: `COEFF_DATA_W] = word_q;
		end
	endgenerate

	// registered read; out-of-range index reads zero
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_out <= `COEFF_RESET_VAL;
		end else if (rd_idx_in < `COEFF_NUM_WORDS) begin
			rd_data_out <=
				all_words_out[rd_idx_in*`COEFF_DATA_W +: `COEFF_DATA_W];
		end else begin
			rd_data_out <= `COEFF_RESET_VAL;
		end
	end

endmodule // coeff_word_store

`default_nettype wire

// File: tb/coeff_host_model.sv
// host controller model driving the register port
`timescale 1ns/1ps
`default_nettype none
module coeff_host_model (
	input  wire logic        mclk_in,
	input  wire logic [23:0] rdata_in,
	output var  logic        wr_out = 1'b0,
	output var  logic [7:0]  addr_out = 8'h00,
	output var  logic [23:0] wdata_out = 24'h000000
);
	// one-cycle strobe; data is scrambled afterwards so no stale hold
	task automatic wr_word(input logic [7:0] a, input logic [23:0] d);
		@(posedge mclk_in);
		wr_out <= 1'b1;
		addr_out <= a;
		wdata_out <= d;
		@(posedge mclk_in);
		wr_out <= 1'b0;
		wdata_out <= ~d;
	endtask
	// address at one edge, read data settles after the next
	task automatic rd_word(input logic [7:0] a, output logic [23:0] d);
		@(posedge mclk_in);
		addr_out <= a;
		@(posedge mclk_in);
		#1 d = rdata_in;
	endtask
endmodule // coeff_host_model
`default_nettype wire

// File: tb/nonlinearity_coeff_regs_monitor.sv
// port checker for the coefficient bank
`timescale 1ns/1ps
`default_nettype none
module nonlinearity_coeff_regs_monitor (
	input wire logic        mclk_in,
	input wire logic        rst_n_in,
	input wire logic        reg_wr_in,
	input wire logic [7:0]  reg_addr_in,
	input wire logic [23:0] reg_wdata_in,
	input wire logic        reg_hit_out,
	input wire logic [23:0] reg_rdata_out,
	input wire logic        meas_start_in,
	input wire logic [1:0]  meas_ch_in,
	input wire logic [15:0] quadratic_out,
	input wire logic        quartic_valid_out,
	input wire logic [15:0] quadratic_high_ch0_out,
	input wire logic [15:0] quartic_low_ch1_out
);
	// single domain, so one clock and one reset for all
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	a_unmapped_zero: assert property (!reg_hit_out |=>
		reg_rdata_out == 24'h0) else $error("unmapped read not zero");
	a_write_readback: assert property (reg_wr_in && reg_hit_out
		##1 !reg_wr_in && $stable(reg_addr_in)
		|=> reg_rdata_out == $past(reg_wdata_in, 2))
		else $error("readback differs");
	a_ac_fields: assert property (reg_wr_in && reg_addr_in == 8'hAC
		##1 !reg_wr_in |=> quadratic_high_ch0_out ==
		$past(reg_wdata_in[15:0], 2) && quartic_low_ch1_out[15:8]
		== $past(reg_wdata_in[23:16], 2)) else $error("word AC view");
	a_ad_low_byte: assert property (reg_wr_in && reg_addr_in == 8'hAD
		##1 !reg_wr_in |=> quartic_low_ch1_out[7:0] ==
		$past(reg_wdata_in[23:16], 2)) else $error("word AD view");
	a_sel_hold: assert property (!meas_start_in |=> $stable(quadratic_out)
		&& $stable(quartic_valid_out)) else $error("selection moved");
	a_ch1_quartic: assert property (meas_start_in && meas_ch_in == 2'h1
		|=> quartic_valid_out) else $error("ch1 quartic missing");
	a_ch0_no_quartic: assert property (meas_start_in && meas_ch_in == 2'h0
		|=> !quartic_valid_out) else $error("ch0 quartic flagged");
	a_none_zero: assert property (meas_start_in && meas_ch_in == 2'h3
		|=> quadratic_out == 16'h0) else $error("ch3 not zero");
endmodule // nonlinearity_coeff_regs_monitor
bind nonlinearity_coeff_regs nonlinearity_coeff_regs_monitor
	i_nonlinearity_coeff_regs_monitor (.mclk_in, .rst_n_in, .reg_wr_in,
	.reg_addr_in, .reg_wdata_in, .reg_hit_out, .reg_rdata_out,
	.meas_start_in, .meas_ch_in, .quadratic_out, .quartic_valid_out,
	.quadratic_high_ch0_out, .quartic_low_ch1_out);
`default_nettype wire

// File: tb/tb_nonlinearity_coeff_regs.sv
// self-checking bench for the coefficient bank
`timescale 1ns/1ps
`default_nettype none
module tb_nonlinearity_coeff_regs;
	logic        mclk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        meas_start_in = 1'b0;
	logic [1:0]  meas_ch_in = 2'h0;
	logic        meas_high_in = 1'b0;
	logic        reg_wr_in, reg_hit_out, quartic_valid_out;
	logic [7:0]  reg_addr_in;
	logic [23:0] reg_wdata_in, reg_rdata_out, rd, w [6];
	logic [15:0] quadratic_out, quartic_out, fv [8];
	int          fails = 0;
	int          cmp_count = 0;
	nonlinearity_coeff_regs i_nonlinearity_coeff_regs (.mclk_in, .rst_n_in,
		.reg_wr_in, .reg_addr_in, .reg_wdata_in, .reg_hit_out,
		.reg_rdata_out, .meas_start_in, .meas_ch_in, .meas_high_in,
		.quadratic_out, .quartic_out, .quartic_valid_out,
		.quadratic_high_ch0_out(fv[0]), .quadratic_low_ch1_out(fv[1]),
		.quadratic_high_ch1_out(fv[2]), .quadratic_low_ch2_out(fv[3]),
		.quadratic_high_ch2_out(fv[4]), .quartic_low_ch1_out(fv[5]),
		.quartic_high_ch1_out(fv[6]), .quartic_low_ch2_out(fv[7]));
	coeff_host_model i_coeff_host_model (.mclk_in, .rdata_in(reg_rdata_out),
		.wr_out(reg_wr_in), .addr_out(reg_addr_in), .wdata_out(reg_wdata_in));
	initial forever #12.5 mclk_in = ~mclk_in;
	task automatic chk(input string n, input logic [23:0] e, g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// all words read back, then every flat view against the same words
	task automatic check_all();
		for (int i = 0; i < 6; i++) begin
			i_coeff_host_model.rd_word(8'hAC + i[7:0], rd);
			chk("word", w[i], rd);
			chk("hit", 24'h1, {23'h0, reg_hit_out});
		end
		for (int i = 0; i < 5; i++)
			chk("quad view", {8'h0, w[i][15:0]}, {8'h0, fv[i]});
		for (int i = 0; i < 3; i++)
			chk("quartic view", {8'h0, w[2*i][23:16], w[2*i+1][23:16]},
				{8'h0, fv[5+i]});
	endtask
	// latch a set; the edge that takes the pulse updates the outputs
	task automatic meas(input logic [1:0] c, input logic h);
		@(posedge mclk_in);
		meas_start_in <= 1'b1;
		meas_ch_in <= c;
		meas_high_in <= h;
		@(posedge mclk_in);
		meas_start_in <= 1'b0;
		#1;
	endtask
	task automatic t_write();
		for (int i = 0; i < 6; i++) begin
			w[i] = {8'hC0 + i[7:0], 8'h50 + i[7:0], 8'h30 + i[7:0]};
			i_coeff_host_model.wr_word(8'hAC + i[7:0], w[i]);
		end
		check_all();
		$display("write test done");
	endtask
	task automatic t_unmapped();
		logic [7:0] a [3] = '{8'hAB, 8'hB2, 8'hB4};
		for (int i = 0; i < 3; i++) begin
			i_coeff_host_model.wr_word(a[i], 24'hFFFFFF);
			i_coeff_host_model.rd_word(a[i], rd);
			chk("unmapped", 24'h0, rd);
			chk("hit", 24'h0, {23'h0, reg_hit_out});
		end
		check_all();
		$display("unmapped test done");
	endtask
	task automatic t_select();
		logic [1:0] c [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
		int q [6] = '{0, 1, 2, 3, 4, 6};
		int k [6] = '{6, 0, 2, 4, 6, 6};
		logic [23:0] x [7];
		x = '{w[0], w[1], w[2], w[3], w[4], w[5], 24'h0};
		for (int i = 0; i < 6; i++) begin
			meas(c[i], ~i[0]);
			chk("quad", {8'h0, x[q[i]][15:0]}, {8'h0, quadratic_out});
			chk("valid", {23'h0, k[i] != 6}, {23'h0, quartic_valid_out});
			if (k[i] != 6)
				chk("quartic", {8'h0, x[k[i]][23:16], x[k[i]+1][23:16]},
					{8'h0, quartic_out});
		end
		meas(2'h1, 1'b0);
		i_coeff_host_model.wr_word(8'hAD, 24'h9ABCDE);
		repeat (2) @(posedge mclk_in);
		#1;
		chk("held", {8'h0, w[1][15:0]}, {8'h0, quadratic_out});
		meas(2'h1, 1'b0);
		chk("updated", 24'h00BCDE, {8'h0, quadratic_out});
		chk("new quartic", {8'h0, w[0][23:16], 8'h9A},
			{8'h0, quartic_out});
		$display("select test done");
	endtask
	task automatic t_reset();
		if (rst_n_in)
			@(posedge mclk_in);
		rst_n_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		chk("reset quad", 24'h0, {8'h0, quadratic_out});
		chk("reset quartic", 24'h0, {8'h0, quartic_out});
		chk("reset valid", 24'h0, {23'h0, quartic_valid_out});
		w = '{default: 24'h0};
		check_all();
		$display("reset test done");
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// reset values, writes, refusals, selection, then a second reset
	initial begin
		t_reset();
		t_write();
		t_unmapped();
		t_select();
		t_reset();
		tally_and_finish();
	end
endmodule // tb_nonlinearity_coeff_regs
`default_nettype wire
